// >>> verif/gtb_timer_test.sv
// Purpose: self-checking bench for the dual half timer block
// Assumes: inputs change on the falling edge; each write is a one-cycle strobe
// Notes: one real seconds tick is driven, 32768 reference edges, the first 20 at four clocks each and the rest at two
`timescale 1ns/10ps
module gtb_timer_test;
    import gtb_pkg::*;
    localparam int W_CFG = 0, W_MODE = 1, W_LOAD = 2, W_PRESC = 3;
    localparam int W_MATCH = 4, W_CTL = 5, W_CLR = 6;
    logic clk_i;
    logic reset_i;
    logic cfg_wr_i;
    logic [2:0] cfg_data_i;
    logic [1:0] mode_wr_i;
    logic [1:0] mode_data_i;
    logic [1:0] load_wr_i;
    logic [31:0] load_data_i;
    logic [1:0] presc_wr_i;
    logic [7:0] presc_data_i;
    logic match_wr_i;
    logic [31:0] match_data_i;
    logic ctl_wr_i;
    gtb_ctl_t ctl_data_i;
    logic [ST_WIDTH-1:0] mask_i;
    logic clear_wr_i;
    logic [ST_WIDTH-1:0] clear_data_i;
    logic debug_halt_i;
    logic capture_compare_pin_i;
    logic [31:0] first_count_value_o;
    logic [15:0] second_count_value_o;
    gtb_ctl_t control_o;
    logic [ST_WIDTH-1:0] raw_status_o;
    logic [ST_WIDTH-1:0] masked_status_o;
    logic irq_o;
    int num_errors;
    int n_tests;
    int n;

    // device under test, every port wired by name
    gtb_timer DUT (.clk_i(clk_i), .reset_i(reset_i), .cfg_wr_i(cfg_wr_i),
        .cfg_data_i(cfg_data_i), .mode_wr_i(mode_wr_i), .mode_data_i(mode_data_i),
        .load_wr_i(load_wr_i), .load_data_i(load_data_i), .presc_wr_i(presc_wr_i),
        .presc_data_i(presc_data_i), .match_wr_i(match_wr_i), .match_data_i(match_data_i),
        .ctl_wr_i(ctl_wr_i), .ctl_data_i(ctl_data_i), .mask_i(mask_i),
        .clear_wr_i(clear_wr_i), .clear_data_i(clear_data_i), .debug_halt_i(debug_halt_i),
        .capture_compare_pin_i(capture_compare_pin_i),
        .first_count_value_o(first_count_value_o), .second_count_value_o(second_count_value_o),
        .control_o(control_o), .raw_status_o(raw_status_o),
        .masked_status_o(masked_status_o), .irq_o(irq_o));

    // 200 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // compare a design value, unknowns never match
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // compare a cycle count measured by the bench
    task automatic chk_cnt(input int got, input int exp, input string msg);
        n_tests++;
        if (got != exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %0d expected %0d", $time, msg, got, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one write: strobe up for one rising edge, then a spare cycle so strobes never touch
    task automatic pulse(input int which, input int half, input logic [31:0] d);
        cfg_data_i = d[2:0];
        mode_data_i = d[1:0];
        load_data_i = d;
        presc_data_i = d[7:0];
        match_data_i = d;
        ctl_data_i = gtb_ctl_t'(d[4:0]);
        clear_data_i = d[2:0];
        case (which)
            W_CFG: cfg_wr_i = 1'b1;
            W_MODE: mode_wr_i[half] = 1'b1;
            W_LOAD: load_wr_i[half] = 1'b1;
            W_PRESC: presc_wr_i[half] = 1'b1;
            W_MATCH: match_wr_i = 1'b1;
            W_CTL: ctl_wr_i = 1'b1;
            default: clear_wr_i = 1'b1;
        endcase
        @(negedge clk_i);
        {cfg_wr_i, mode_wr_i, load_wr_i, presc_wr_i, match_wr_i, ctl_wr_i, clear_wr_i} = '0;
        @(negedge clk_i);
    endtask

    // bounded wait for a raw flag; cnt is the number of falling edges waited
    task automatic wait_raw(input int b, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk_i);
            cnt++;
        end while (raw_status_o[b] !== 1'b1 && cnt < lim);
        if (raw_status_o[b] !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: flag %0d never rose", $time, b);
            summarize();
        end
    endtask

    task automatic t_reset();
        reset_i = 1'b1;
        repeat (12) @(negedge clk_i);
        reset_i = 1'b0;
        chk_val(first_count_value_o, {CNT_RST, CNT_RST}, "count");
        chk_val(second_count_value_o, CNT_RST, "second count");
        chk_val(control_o, CTL_RST, "control");
        chk_val({raw_status_o, masked_status_o, irq_o}, 7'h00, "flags");
        $display("test reset done");
    endtask

    task automatic t_oneshot32();
        mask_i = 3'h1;
        pulse(W_MODE, 0, MODE_ONE_SHOT);
        pulse(W_MODE, 1, MODE_PERIODIC);
        pulse(W_LOAD, 0, 32'h0001_0002);
        chk_val(first_count_value_o, 32'h0001_0002, "chained load");
        chk_val(second_count_value_o, 16'h0001, "upper half");
        pulse(W_CTL, 0, 32'h01);
        for (n = 0; n < 8 && first_count_value_o !== 32'h0001_0000; n++) @(negedge clk_i);
        @(negedge clk_i);
        chk_val(first_count_value_o, 32'h0000_FFFF, "borrow");
        // load while running: new value next edge, then one step
        pulse(W_LOAD, 0, 32'h5);
        chk_val(first_count_value_o, 32'h4, "live load");
        wait_raw(0, 20, n);
        chk_cnt(n, 5, "time-out delay");
        chk_val(first_count_value_o, 32'h5, "reload");
        chk_val(control_o.first_run_bit, 1'b0, "one-shot stop");
        chk_val({masked_status_o[0], irq_o}, 2'h3, "masked");
        repeat (3) @(negedge clk_i);
        chk_val(first_count_value_o, 32'h5, "stays stopped");
        pulse(W_CLR, 0, 32'h0);
        chk_val(raw_status_o, 3'h1, "zero clear");
        pulse(W_CLR, 0, 32'h1);
        chk_val({raw_status_o, masked_status_o, irq_o}, 7'h00, "cleared");
        $display("test one-shot 32 done");
    endtask

    task automatic t_periodic32();
        logic [31:0] c;
        pulse(W_MODE, 0, MODE_PERIODIC);
        pulse(W_MODE, 1, MODE_ONE_SHOT);
        pulse(W_LOAD, 0, 32'h3);
        pulse(W_CTL, 0, 32'h01);
        wait_raw(0, 20, n);
        pulse(W_CLR, 0, 32'h1);
        wait_raw(0, 20, n);
        chk_cnt(n + 2, 4, "period");
        chk_val(control_o.first_run_bit, 1'b1, "keeps running");
        // freeze while halted, but not with the seconds enable set
        debug_halt_i = 1'b1;
        pulse(W_CTL, 0, 32'h05);
        c = first_count_value_o;
        repeat (6) @(negedge clk_i);
        chk_val(first_count_value_o, c, "frozen");
        pulse(W_CTL, 0, 32'h15);
        c = first_count_value_o;
        @(negedge clk_i);
        chk_val(first_count_value_o, (c == 32'h0) ? 32'h3 : c - 32'h1, "no freeze");
        debug_halt_i = 1'b0;
        pulse(W_CTL, 0, 32'h0);
        pulse(W_CLR, 0, 32'h7);
        $display("test periodic 32 done");
    endtask

    task automatic t_split();
        int pv[3] = '{0, 3, 255};
        logic [15:0] s;
        mask_i = 3'h2;
        pulse(W_CFG, 0, CFG_16_SPLIT);
        pulse(W_MODE, 1, MODE_PERIODIC);
        foreach (pv[i]) begin
            pulse(W_PRESC, 1, pv[i]);
            pulse(W_LOAD, 1, 32'h3);
            pulse(W_CTL, 0, 32'h02);
            wait_raw(1, 1100, n);
            chk_val(irq_o, 1'b1, "half irq");
            pulse(W_CLR, 0, 32'h2);
            wait_raw(1, 1100, n);
            chk_cnt(n + 2, 4 * (pv[i] + 1), "prescaled period");
            pulse(W_CTL, 0, 32'h0);
            pulse(W_CLR, 0, 32'h2);
        end
        pulse(W_MODE, 0, MODE_ONE_SHOT);
        pulse(W_PRESC, 0, 32'h1);
        s = second_count_value_o;
        pulse(W_LOAD, 0, 32'hABCD_0002);
        chk_val(first_count_value_o, {s, 16'h0002}, "split load");
        pulse(W_CTL, 0, 32'h03);
        wait_raw(0, 40, n);
        chk_val(control_o, 32'h02, "only first stops");
        chk_val(first_count_value_o[15:0], 16'h0002, "half reload");
        chk_val(masked_status_o[0], 1'b0, "mask off");
        pulse(W_CTL, 0, 32'h0);
        pulse(W_CLR, 0, 32'h7);
        $display("test split done");
    endtask

    task automatic t_seconds();
        mask_i = 3'h4;
        pulse(W_CFG, 0, CFG_32_SEC);
        chk_val(first_count_value_o, SEC_START, "seconds entry");
        pulse(W_MATCH, 0, 32'h1);
        pulse(W_CTL, 0, 32'h11);
        // reference pin toggles every two clocks, far short of one tick
        for (int i = 0; i < 40; i++) begin
            capture_compare_pin_i = ~capture_compare_pin_i;
            repeat (2) @(negedge clk_i);
        end
        chk_val(first_count_value_o, SEC_START, "no early tick");
        chk_val(raw_status_o[2], 1'b0, "no match");
        // the remaining edges of the first second; count sits on the match value
        for (int i = 20; i < 32768; i++) begin
            capture_compare_pin_i = 1'b1;
            @(negedge clk_i);
            capture_compare_pin_i = 1'b0;
            @(negedge clk_i);
        end
        chk_val(first_count_value_o, SEC_WRAP, "wrap on match");
        chk_val({raw_status_o[2], masked_status_o[2], irq_o}, 3'h7, "match flag");
        pulse(W_CTL, 0, 32'h0);
        pulse(W_CFG, 0, CFG_32_TIMER);
        pulse(W_LOAD, 0, 32'h77);
        pulse(W_CFG, 0, CFG_32_SEC);
        chk_val(first_count_value_o, 32'h77, "re-entry keeps count");
        $display("test seconds done");
    endtask

    task automatic t_presc_reset();
        logic [31:0] c;
        pulse(W_CFG, 0, CFG_16_SPLIT);
        pulse(W_CTL, 0, 32'h01);
        c = first_count_value_o;
        chk_val(c[15:8], 8'hFF, "start near load");
        @(negedge clk_i);
        chk_val(first_count_value_o[15:0], c[15:0] - 16'h1, "step per clock");
        $display("test prescale reset done");
    endtask

    // main sequence, ending in the single verdict
    initial begin
        num_errors = 0;
        n_tests = 0;
        reset_i = 1'b1;
        {cfg_wr_i, mode_wr_i, load_wr_i, presc_wr_i, match_wr_i, ctl_wr_i, clear_wr_i} = '0;
        {cfg_data_i, mode_data_i, load_data_i, presc_data_i, match_data_i} = '0;
        ctl_data_i = CTL_RST;
        {mask_i, clear_data_i, debug_halt_i, capture_compare_pin_i} = '0;
        t_reset();
        t_oneshot32();
        t_periodic32();
        t_split();
        t_seconds();
        t_reset();
        t_presc_reset();
        summarize();
    end
endmodule

// >>> verilog/gtb_pkg.sv
// Purpose: shared constants and types for the dual half timer block
// Assumes: one 200 MHz clock, plain control ports, no register bus
// Notes: status vector positions are used by the top and the status module
package gtb_pkg;
    // configuration codes
    localparam logic [2:0] CFG_32_TIMER = 3'h0;
    localparam logic [2:0] CFG_32_SEC = 3'h1;
    localparam logic [2:0] CFG_16_SPLIT = 3'h4;
    localparam logic [2:0] CFG_RST = 3'h0;
    // half mode field codes
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_RST = 2'h0;
    // reset values, seconds entry and wrap values
    localparam logic [15:0] CNT_RST = 16'hFFFF;
    localparam logic [15:0] LOAD_RST = 16'hFFFF;
    localparam logic [7:0] PRESC_RST = 8'h00;
    localparam logic [31:0] MATCH_RST = 32'h0000_0000;
    localparam logic [31:0] SEC_START = 32'h0000_0001;
    localparam logic [31:0] SEC_WRAP = 32'h0000_0000;
    // status bit positions
    localparam int ST_FIRST_TIMEOUT = 0;
    localparam int ST_SECOND_TIMEOUT = 1;
    localparam int ST_SECONDS_MATCH = 2;
    localparam int ST_WIDTH = 3;
    // seconds divider: 32.768 KHz reference edges per 1 Hz tick
    localparam int SEC_DIV = 32768;
    localparam int SEC_DIV_W = 15;
    localparam logic [SEC_DIV_W-1:0] SEC_DIV_LAST = 15'h7FFF;

    // control register fields
    typedef struct packed {
        logic seconds_counter_enable;
        logic second_debug_freeze;
        logic first_debug_freeze;
        logic second_run_bit;
        logic first_run_bit;
    } gtb_ctl_t;
    localparam gtb_ctl_t CTL_RST = '{default: 1'b0};
endpackage

// >>> verilog/gtb_sec_div.sv
// Purpose: divide the 32.768 KHz reference on the capture pin to a 1 Hz tick
// Assumes: reference is synchronous to clk_i and well below half its rate
// Notes: divider restarts whenever it is disabled
`timescale 1ns/10ps
module gtb_sec_div (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // control and reference
    input wire logic enable_i,
    input wire logic ref_i,
    // one-cycle tick per second
    output logic tick_o
);
    import gtb_pkg::*;

    logic ref_last;
    logic [SEC_DIV_W-1:0] edge_cnt;
    logic ref_rise;

    assign ref_rise = ref_i & ~ref_last;

    // count reference rising edges, pulse on the last one of each second
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_last <= 1'b0;
            edge_cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            ref_last <= ref_i;
            tick_o <= 1'b0;
            if (!enable_i) begin
                edge_cnt <= '0;
            end else if (ref_rise) begin
                if (edge_cnt == SEC_DIV_LAST) begin
                    edge_cnt <= '0;
                    tick_o <= 1'b1; // see RQ14
                end else begin
                    edge_cnt <= edge_cnt + 1'b1;
                end
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_tick_single: assert property (tick_o |=> !tick_o) // see RQ14
        else $error("seconds tick longer than one cycle");
endmodule

// >>> verilog/gtb_status.sv
// Purpose: raw and masked status flags with one combined interrupt
// Assumes: set and clear are one-cycle pulses in the clk_i domain
// Notes: a set in the same cycle as its clear wins
`timescale 1ns/10ps
module gtb_status (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // events and software clear
    input wire logic [gtb_pkg::ST_WIDTH-1:0] set_i,
    input wire logic [gtb_pkg::ST_WIDTH-1:0] clear_i,
    input wire logic [gtb_pkg::ST_WIDTH-1:0] mask_i,
    // flags
    output logic [gtb_pkg::ST_WIDTH-1:0] raw_o,
    output logic [gtb_pkg::ST_WIDTH-1:0] masked_o,
    output logic irq_o
);
    import gtb_pkg::*;

    logic [ST_WIDTH-1:0] next_raw;

    // per flag: hold until a one is written to its clear bit
    for (genvar i = 0; i < ST_WIDTH; i++) begin : g_flag
        assign next_raw[i] = set_i[i] | (raw_o[i] & ~clear_i[i]); // see RQ23
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                raw_o[i] <= 1'b0;
                masked_o[i] <= 1'b0;
            end else begin
                raw_o[i] <= next_raw[i]; // see RQ10 see RQ16 see RQ21
                masked_o[i] <= next_raw[i] & mask_i[i]; // see RQ24
            end
        end
    end

    // interrupt registered from the same next values so it tracks masked_o exactly
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(next_raw & mask_i); // see RQ24
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_set_wins: assert property (|set_i |-> ##1 ((raw_o & $past(set_i)) == $past(set_i))) // see RQ10
        else $error("status event lost");
    chk_irq_follows: assert property (irq_o == |masked_o && masked_o == (raw_o & $past(mask_i))) // see RQ24
        else $error("interrupt does not match masked flags");
    chk_clear_works: assert property ((|clear_i && !(|set_i)) |=> ((raw_o & $past(clear_i)) == '0)) // see RQ23
        else $error("clear did not drop flag");
endmodule

// >>> verilog/gtb_timer.sv
// Purpose: two 16-bit halves usable as one 32-bit timer, a seconds counter or two timers
// Assumes: all control inputs are synchronous one-cycle write strobes with data
// Notes: count outputs come straight from the counter flops
// Behaviour
// RQ1: after reset the block is idle and control state takes its defaults
// RQ2: both counters and both interval loads reset to all ones
// RQ3: both prescale counters and prescale settings reset to zero
// RQ4: config 0 is chained 32-bit timer, config 1 is chained seconds counter
// RQ5: config 4 splits into two independent 16-bit timers
// RQ6: in 32-bit configs a first load write fills both loads, low then high
// RQ7: in 32-bit configs the first count reads second count above first count
// RQ8: chained 32-bit timer counts down, one-shot or periodic from first mode only
// RQ9: run bit starts countdown; reload after zero; one-shot stops and clears run
// RQ10: 32-bit time-out sets sticky raw flag, and masked flag when unmasked
// RQ11: a load write while running takes effect the next cycle
// RQ12: with freeze set the timer holds its count during a debug halt
// RQ13: seconds counter counts up, starting at one on first entry
// RQ14: a 32.768 KHz reference on the capture pin is divided to 1 Hz
// RQ15: seconds counter wraps to zero on match and runs until disabled
// RQ16: seconds match sets raw flag, masked flag and interrupt until cleared
// RQ17: with seconds enable set the freeze bits have no effect
// RQ18: split halves are 16-bit down-counters with optional 8-bit prescaler
// RQ19: prescale p makes each count step last p+1 clocks
// RQ20: a half reloads count and prescale after zero; one-shot clears its run bit
// RQ21: a half time-out sets its sticky raw flag and masked flag when unmasked
// RQ22: mode field 1 is one-shot and 2 is periodic
// RQ23: writing one to a clear bit drops raw and masked flags, zero leaves them
// RQ24: masked flag is raw and mask, interrupt is the or of masked flags
`timescale 1ns/10ps
module gtb_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // configuration and modes
    input wire logic cfg_wr_i,
    input wire logic [2:0] cfg_data_i,
    input wire logic [1:0] mode_wr_i,
    input wire logic [1:0] mode_data_i,
    // interval loads, prescale and match
    input wire logic [1:0] load_wr_i,
    input wire logic [31:0] load_data_i,
    input wire logic [1:0] presc_wr_i,
    input wire logic [7:0] presc_data_i,
    input wire logic match_wr_i,
    input wire logic [31:0] match_data_i,
    // control, mask and clear
    input wire logic ctl_wr_i,
    input wire gtb_pkg::gtb_ctl_t ctl_data_i,
    input wire logic [gtb_pkg::ST_WIDTH-1:0] mask_i,
    input wire logic clear_wr_i,
    input wire logic [gtb_pkg::ST_WIDTH-1:0] clear_data_i,
    // debug and reference pin
    input wire logic debug_halt_i,
    input wire logic capture_compare_pin_i,
    // readback
    output logic [31:0] first_count_value_o,
    output logic [15:0] second_count_value_o,
    output gtb_pkg::gtb_ctl_t control_o,
    // status
    output logic [gtb_pkg::ST_WIDTH-1:0] raw_status_o,
    output logic [gtb_pkg::ST_WIDTH-1:0] masked_status_o,
    output logic irq_o
);
    import gtb_pkg::*;

    logic [2:0] block_configuration;
    logic [1:0] half_mode_reg [2];
    logic [15:0] half_interval_load [2];
    logic [7:0] half_prescale [2];
    logic [7:0] presc_cnt [2];
    logic [15:0] cnt [2];
    logic [31:0] first_match_value;
    gtb_ctl_t ctl;
    logic seconds_seen;
    logic sec_tick;
    logic [31:0] cnt32;
    logic mode32;
    logic mode_sec;
    logic mode16;
    logic [1:0] run;
    logic [1:0] stall;
    logic [1:0] step16;
    logic sec_entry;
    logic [ST_WIDTH-1:0] event_set;
    logic [ST_WIDTH-1:0] event_clear;
    logic oneshot_done_32;
    logic [1:0] oneshot_done_16;

    // decode of the configuration and the run conditions
    assign cnt32 = {cnt[1], cnt[0]};
    assign mode32 = (block_configuration == CFG_32_TIMER); // see RQ4
    assign mode_sec = (block_configuration == CFG_32_SEC); // see RQ4
    assign mode16 = (block_configuration == CFG_16_SPLIT); // see RQ5
    assign run = {ctl.second_run_bit, ctl.first_run_bit};
    // freeze is ignored entirely once the seconds counter is enabled
    assign stall[0] = ctl.first_debug_freeze & debug_halt_i & ~ctl.seconds_counter_enable; // see RQ12 see RQ17
    assign stall[1] = ctl.second_debug_freeze & debug_halt_i & ~ctl.seconds_counter_enable; // see RQ17
    assign sec_entry = cfg_wr_i && (cfg_data_i == CFG_32_SEC) && !seconds_seen;

    // a half steps when its prescale counter has run out
    for (genvar h = 0; h < 2; h++) begin : g_step
        assign step16[h] = mode16 && run[h] && !stall[h] && (presc_cnt[h] == PRESC_RST); // see RQ19
        assign oneshot_done_16[h] = step16[h] && (cnt[h] == 16'h0000)
            && (half_mode_reg[h] != MODE_PERIODIC); // see RQ22
    end
    // the second half's mode is never looked at when chained
    assign oneshot_done_32 = mode32 && run[0] && !stall[0] && (cnt32 == 32'h0000_0000)
        && (half_mode_reg[0] != MODE_PERIODIC); // see RQ8

    // time-out and match events
    assign event_set[ST_FIRST_TIMEOUT] = (mode32 && run[0] && !stall[0] && cnt32 == 32'h0000_0000)
        || (step16[0] && cnt[0] == 16'h0000); // see RQ10 see RQ21
    assign event_set[ST_SECOND_TIMEOUT] = step16[1] && (cnt[1] == 16'h0000); // see RQ21
    assign event_set[ST_SECONDS_MATCH] = mode_sec && run[0] && sec_tick
        && (cnt32 == first_match_value); // see RQ16
    assign event_clear = clear_wr_i ? clear_data_i : '0; // see RQ23

    // configuration, mode and match registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            block_configuration <= CFG_RST; // see RQ1
            half_mode_reg[0] <= MODE_RST;
            half_mode_reg[1] <= MODE_RST;
            first_match_value <= MATCH_RST;
            seconds_seen <= 1'b0;
        end else begin
            if (cfg_wr_i) begin
                block_configuration <= cfg_data_i;
            end
            if (sec_entry) begin
                seconds_seen <= 1'b1;
            end
            for (int h = 0; h < 2; h++) begin
                if (mode_wr_i[h]) begin
                    half_mode_reg[h] <= mode_data_i;
                end
            end
            if (match_wr_i) begin
                first_match_value <= match_data_i;
            end
        end
    end

    // interval load and prescale settings
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int h = 0; h < 2; h++) begin
                half_interval_load[h] <= LOAD_RST; // see RQ2
                half_prescale[h] <= PRESC_RST; // see RQ3
            end
        end else begin
            if (load_wr_i[0] && !mode16) begin
                half_interval_load[0] <= load_data_i[15:0]; // see RQ6
                half_interval_load[1] <= load_data_i[31:16];
            end else begin
                for (int h = 0; h < 2; h++) begin
                    if (load_wr_i[h]) begin
                        half_interval_load[h] <= load_data_i[15:0];
                    end
                end
            end
            for (int h = 0; h < 2; h++) begin
                if (presc_wr_i[h]) begin
                    half_prescale[h] <= presc_data_i;
                end
            end
        end
    end

    // control register: hardware clears run bits when a one-shot ends
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctl <= CTL_RST; // see RQ1
        end else if (ctl_wr_i) begin
            ctl <= ctl_data_i;
        end else begin
            if (oneshot_done_32 || oneshot_done_16[0]) begin
                ctl.first_run_bit <= 1'b0; // see RQ9 see RQ20
            end
            if (oneshot_done_16[1]) begin
                ctl.second_run_bit <= 1'b0; // see RQ20
            end
        end
    end

    // counters; later statements override earlier ones, load writes last
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int h = 0; h < 2; h++) begin
                cnt[h] <= CNT_RST; // see RQ2
                presc_cnt[h] <= PRESC_RST; // see RQ3
            end
        end else begin
            for (int h = 0; h < 2; h++) begin
                if (mode16 && run[h] && !stall[h]) begin
                    if (presc_cnt[h] != PRESC_RST) begin
                        presc_cnt[h] <= presc_cnt[h] - 8'h01; // see RQ19
                    end else begin
                        presc_cnt[h] <= half_prescale[h]; // see RQ20
                        cnt[h] <= (cnt[h] == 16'h0000) ? half_interval_load[h]
                            : cnt[h] - 16'h0001; // see RQ18 see RQ20
                    end
                end
            end
            if (mode32 && run[0] && !stall[0]) begin
                {cnt[1], cnt[0]} <= (cnt32 == 32'h0000_0000)
                    ? {half_interval_load[1], half_interval_load[0]}
                    : cnt32 - 32'h0000_0001; // see RQ8 see RQ9
            end
            if (mode_sec && run[0] && sec_tick) begin
                {cnt[1], cnt[0]} <= (cnt32 == first_match_value) ? SEC_WRAP
                    : cnt32 + 32'h0000_0001; // see RQ13 see RQ15
            end
            if (sec_entry) begin
                {cnt[1], cnt[0]} <= SEC_START; // see RQ13
            end
            // a new interval replaces the running count one cycle later
            if (load_wr_i[0] && !mode16) begin
                {cnt[1], cnt[0]} <= load_data_i; // see RQ11
            end else begin
                for (int h = 0; h < 2; h++) begin
                    if (load_wr_i[h] && mode16) begin
                        cnt[h] <= load_data_i[15:0]; // see RQ11
                    end
                end
            end
        end
    end

    // readback straight from the counter and control flops
    assign first_count_value_o = cnt32; // see RQ7
    assign second_count_value_o = cnt[1];
    assign control_o = ctl;

    // seconds reference divider runs only while the seconds counter runs
    gtb_sec_div u_sec_div (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .enable_i(mode_sec && run[0]),
        .ref_i(capture_compare_pin_i),
        .tick_o(sec_tick)
    );

    // sticky status flags and interrupt
    gtb_status u_status (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .set_i(event_set),
        .clear_i(event_clear),
        .mask_i(mask_i),
        .raw_o(raw_status_o),
        .masked_o(masked_status_o),
        .irq_o(irq_o)
    );

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_oneshot_stop: assert property (oneshot_done_32 && !ctl_wr_i |=> !ctl.first_run_bit) // see RQ9
        else $error("one-shot did not clear run bit");
    chk_chain_reload: assert property ((mode32 && run[0] && !stall[0] && cnt32 == 32'h0000_0000
        && !(|load_wr_i) && !cfg_wr_i)
        |=> cnt32 == {$past(half_interval_load[1]), $past(half_interval_load[0])}) // see RQ9
        else $error("chained reload value wrong");
    chk_chain_down: assert property ((mode32 && run[0] && !stall[0] && cnt32 != 32'h0000_0000
        && !(|load_wr_i) && !cfg_wr_i) |=> cnt32 == $past(cnt32) - 32'h0000_0001) // see RQ8
        else $error("chained counter did not step down");
    chk_freeze_hold: assert property ((mode32 && stall[0] && !(|load_wr_i) && !cfg_wr_i)
        |=> $stable(cnt32)) // see RQ12
        else $error("frozen timer moved");
    chk_load_next: assert property ((load_wr_i[0] && !mode16) |=> cnt32 == $past(load_data_i)) // see RQ11
        else $error("load write not applied next cycle");
    chk_sec_wrap: assert property ((mode_sec && run[0] && sec_tick && cnt32 == first_match_value
        && !(|load_wr_i) && !cfg_wr_i) |=> cnt32 == SEC_WRAP ##0 raw_status_o[ST_SECONDS_MATCH]) // see RQ15
        else $error("seconds counter did not wrap on match");
    chk_presc_hold: assert property ((mode16 && run[0] && !stall[0] && presc_cnt[0] != PRESC_RST
        && !load_wr_i[0] && !cfg_wr_i) |=> $stable(cnt[0])) // see RQ19
        else $error("half stepped before prescale ran out");
    chk_half_timeout: assert property ((step16[1] && cnt[1] == 16'h0000 && !load_wr_i[1] && !cfg_wr_i)
        |=> cnt[1] == $past(half_interval_load[1]) && raw_status_o[ST_SECOND_TIMEOUT]) // see RQ21
        else $error("half time-out missing reload or flag");
endmodule
